// file: dv/rtf_host_model.sv
// Host side model: register strobes and end of access
// Assumes the bank samples strobes on the rising edge of mclk
`timescale 1ns/1ps
module rtf_host_model (
    input  wire       mclk,
    output reg        reg_wr,
    output reg        reg_rd,
    output reg  [4:0] reg_addr,
    output reg  [7:0] reg_wdata,
    input  wire [7:0] reg_rdata,
    output reg        host_stop
);
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 5'h00;
        reg_wdata = 8'h00;
        host_stop = 1'b0;
    end

    // Idle bus shows the inverse of the last value
    task wr(input [4:0] a, input [7:0] d);
        begin
            @(posedge mclk);
            #1;
            reg_wr = 1'b1;
            reg_addr = a;
            reg_wdata = d;
            @(posedge mclk);
            #1;
            reg_wr = 1'b0;
            reg_addr = ~a;
            reg_wdata = ~d;
        end
    endtask

    task rd(input [4:0] a, output [7:0] d);
        begin
            @(posedge mclk);
            #1;
            reg_rd = 1'b1;
            reg_addr = a;
            @(posedge mclk);
            #1;
            reg_rd = 1'b0;
            reg_addr = ~a;
            d = reg_rdata;
        end
    endtask

    // End of a host access
    task stop;
        begin
            @(posedge mclk);
            #1;
            host_stop = 1'b1;
            @(posedge mclk);
            #1;
            host_stop = 1'b0;
        end
    endtask
endmodule

// file: dv/rtf_props.sv
// Checker of the test and length bank port behaviour
// Assumes a bind onto rtf_test_len_regs, all on mclk
`timescale 1ns/1ps
module rtf_props (
    input wire        mclk,
    input wire        reset_n,
    input wire        chip_enable,
    input wire        reg_wr,
    input wire        reg_rd,
    input wire [4:0]  reg_addr,
    input wire [7:0]  reg_wdata,
    input wire [7:0]  reg_rdata,
    input wire        host_stop,
    input wire        tx_eof,
    input wire        onoff_keying_pin_oe,
    input wire        first_stage_gain_cut,
    input wire        second_stage_select,
    input wire        test_mode,
    input wire [11:0] tx_byte_count,
    input wire [2:0]  partial_byte_bits,
    input wire        partial_byte_flag,
    input wire [3:0]  tx_last_byte_bits
);
    reg  [1:0] ce_cnt_ff;
    wire       ce_ok;
    wire [1:0] nxt_ce_cnt;

    // Enable seen long enough to pass the synchroniser
    assign ce_ok = (ce_cnt_ff == 2'h3);
    assign nxt_ce_cnt = !chip_enable ? 2'h0 :
                        ce_ok ? ce_cnt_ff : ce_cnt_ff + 2'h1;
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            ce_cnt_ff <= 2'h0;
        end else begin
            ce_cnt_ff <= nxt_ce_cnt;
        end
    end

    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);

    rsvd_zero_a: assert property (
        reg_rd && reg_addr == 5'h1c |=> reg_rdata[7] == 1'b0)
        else $error("status reserved bit set");
    stop_clear_a: assert property (
        host_stop ##1 !reg_wr |=> !test_mode)
        else $error("test mode kept after stop");
    test_entry_a: assert property (
        ce_ok && reg_wr && reg_addr == 5'h1b && (|reg_wdata[3:1])
        && !host_stop |-> ##2 test_mode)
        else $error("test mode not entered");
    stage_bits_a: assert property (
        ce_ok && reg_wr && reg_addr == 5'h1a |=> second_stage_select ==
        $past(reg_wdata[4]) && first_stage_gain_cut == $past(reg_wdata[2]))
        else $error("stage bits wrong");
    key_pin_a: assert property (
        ce_ok && reg_wr && reg_addr == 5'h1a |-> ##2
        onoff_keying_pin_oe == !$past(reg_wdata[7], 2))
        else $error("keying pin drive wrong");
    len_high_a: assert property (
        ce_ok && reg_wr && reg_addr == 5'h1d |=>
        tx_byte_count[11:4] == $past(reg_wdata))
        else $error("byte count high wrong");
    eof_clear_a: assert property (
        tx_eof && !reg_wr |=> tx_byte_count == 12'h000 && !partial_byte_flag)
        else $error("length not cleared at frame end");
    last_bits_a: assert property (
        1'b1 |-> tx_last_byte_bits == (partial_byte_flag ?
        {1'b0, partial_byte_bits} : 4'h8))
        else $error("last byte width wrong");
endmodule

bind rtf_test_len_regs rtf_props u_props (
    .mclk(mclk), .reset_n(reset_n), .chip_enable(chip_enable),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .host_stop(host_stop),
    .tx_eof(tx_eof), .onoff_keying_pin_oe(onoff_keying_pin_oe),
    .first_stage_gain_cut(first_stage_gain_cut),
    .second_stage_select(second_stage_select), .test_mode(test_mode),
    .tx_byte_count(tx_byte_count), .partial_byte_bits(partial_byte_bits),
    .partial_byte_flag(partial_byte_flag),
    .tx_last_byte_bits(tx_last_byte_bits)
);

// file: dv/test_rtf_test_len_regs.sv
// Testbench of the test, FIFO status and length bank
// Assumes rtf_host_model for register traffic, 40 MHz mclk
`timescale 1ns/1ps
module test_rtf_test_len_regs;
    reg         mclk, reset_n, chip_enable, push, pop, rx, tx, eof;
    reg         subc, key_in, shp_in, ckey;
    reg  [2:0]  agc;
    reg  [7:0]  d;
    wire        wr, rd, stp, dec_in, shp_out, shp_oe, rx_rst, tmode, fclk;
    wire        kout, tmod, cut2, ifol, clc;
    wire [4:0]  addr;
    wire [7:0]  wdata, rdata;
    wire [2:0]  sstr;
    wire [11:0] bcnt;
    wire [3:0]  lastb;
    integer     n_errors, n_tests, i, cyc;
    reg  [7:0]  codes [0:2];

    always #12.5 mclk = ~mclk;

    rtf_host_model host (.mclk(mclk), .reg_wr(wr), .reg_rd(rd),
        .reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata),
        .host_stop(stp));

    rtf_test_len_regs uut (.mclk(mclk), .reset_n(reset_n),
        .chip_enable(chip_enable), .reg_wr(wr), .reg_rd(rd),
        .reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata),
        .host_stop(stp), .fifo_push(push), .fifo_pop(pop),
        .rx_active(rx), .tx_active(tx), .tx_eof(eof),
        .rx_subcarrier(subc), .coder_modulation(1'b0), .coder_keying(ckey),
        .agc_level(agc), .rssi_level(3'h2), .onoff_keying_pin_in(key_in),
        .onoff_keying_pin_out(kout), .onoff_keying_pin_oe(),
        .tx_shaping_pin_in(shp_in), .tx_shaping_pin_out(shp_out),
        .tx_shaping_pin_oe(shp_oe), .decoder_input(dec_in),
        .tx_modulation(tmod), .rx_reset(rx_rst), .second_stage_select(),
        .second_stage_gain_cut(cut2), .first_stage_gain_cut(),
        .input_follower_test(ifol), .signal_strength(sstr), .test_mode(tmode),
        .fast_coder_clock(fclk), .carrier_level_check(clc),
        .tx_byte_count(bcnt), .partial_byte_bits(), .partial_byte_flag(),
        .tx_last_byte_bits(lastb));

    task chk(input [11:0] g, input [11:0] e);
        begin
            n_tests = n_tests + 1;
            if (g !== e) begin
                n_errors = n_errors + 1;
                $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
            end
        end
    endtask

    task tick(input integer n);
        begin
            repeat (n) @(posedge mclk);
            #1;
        end
    endtask

    // Pulse push or pop n times, every other cycle
    task ev(input p, input q, input integer n);
        begin
            repeat (n) begin
                tick(1);
                push = p;
                pop = q;
                tick(1);
                push = 1'b0;
                pop = 1'b0;
            end
        end
    endtask

    task conclude;
        begin
            $display("errors %0d comparisons %0d", n_errors, n_tests);
            if (n_errors == 0 && n_tests > 0)
                $display("STATUS OK");
            else
                $display("STATUS NOT OK");
            $finish;
        end
    endtask

    always @(posedge mclk) begin
        cyc = cyc + 1;
        if (cyc == 2000) begin
            n_errors = n_errors + 1;
            conclude;
        end
    end

    initial begin
        {mclk, reset_n, push, pop, rx, tx, eof, subc, key_in, shp_in} = 0;
        chip_enable = 1'b1;
        ckey = 1'b1;
        agc = 3'h5;
        {n_errors, n_tests, cyc} = 0;
        codes[0] = 8'h02;
        codes[1] = 8'h04;
        codes[2] = 8'h08;
        tick(10);
        reset_n = 1'b1;
        tick(4);
        for (i = 0; i < 5; i = i + 1) begin
            host.rd(5'h1a + i[4:0], d);
            chk(d, 8'h00);
        end
        chk(kout, 1'b1);
        host.wr(5'h1a, 8'h1d);
        host.rd(5'h1a, d);
        chk(d, 8'h1d);
        chk(sstr, 3'h5);
        host.wr(5'h1a, 8'h0e);
        tick(2);
        chk(sstr, 3'h2);
        chk({ifol, cut2}, 2'h3);
        chip_enable = 1'b0;
        tick(4);
        host.rd(5'h1a, d);
        chk(d, 8'h00);
        chip_enable = 1'b1;
        tick(3);
        key_in = 1'b1;
        host.wr(5'h1a, 8'h80);
        tick(4);
        chk(dec_in, 1'b1);
        subc = 1'b1;
        host.wr(5'h1a, 8'h40);
        tick(2);
        chk({shp_oe, shp_out}, 2'h3);
        host.wr(5'h1a, 8'h20);
        shp_in = 1'b1;
        tick(4);
        chk({shp_oe, tmod, rx_rst}, 3'h3);
        for (i = 0; i < 3; i = i + 1) begin
            host.wr(5'h1b, codes[i]);
            tick(2);
            chk(tmode, 1'b1);
            host.stop;
            tick(2);
            chk(tmode, 1'b0);
        end
        host.wr(5'h1b, 8'hff);
        host.rd(5'h1b, d);
        chk(d, 8'h8f);
        chk({clc, fclk}, 2'h3);
        host.stop;
        host.rd(5'h1b, d);
        chk(d, 8'h81);
        rx = 1'b1;
        ev(1, 0, 8);
        host.rd(5'h1c, d);
        chk(d, 8'h07);
        ev(1, 0, 1);
        host.rd(5'h1c, d);
        chk(d, 8'h48);
        rx = 1'b0;
        tx = 1'b1;
        ev(0, 1, 6);
        host.rd(5'h1c, d);
        chk(d, 8'h22);
        ev(1, 0, 10);
        host.rd(5'h1c, d);
        chk(d, 8'h1b);
        host.rd(5'h1c, d);
        chk(d, 8'h0b);
        // Host loads the count before sending
        host.wr(5'h1d, 8'hab);
        host.wr(5'h1e, 8'hc7);
        tick(1);
        chk(bcnt, 12'habc);
        chk(lastb, 4'h3);
        host.wr(5'h1e, 8'hc6);
        tick(1);
        chk(lastb, 4'h8);
        eof = 1'b1;
        tick(1);
        eof = 1'b0;
        host.rd(5'h1d, d);
        chk(d, 8'h00);
        host.rd(5'h1e, d);
        chk(d, 8'h00);
        conclude;
    end
endmodule

// file: verilog/rtf_defs.vh
// Register map, field positions and reset values of the test and length bank
// Assumes a byte wide register port with a 5 bit register index
`ifndef RTF_DEFS_VH
`define RTF_DEFS_VH

`define RTF_ADDR_W         5
`define RTF_DATA_W         8
`define RTF_ADDR_TEST_A    5'h1a
`define RTF_ADDR_TEST_B    5'h1b
`define RTF_ADDR_FIFO_STAT 5'h1c
`define RTF_ADDR_TXLEN_HI  5'h1d
`define RTF_ADDR_TXLEN_LO  5'h1e
`define RTF_RESET_BYTE     8'h00

// Test control A fields
`define RTF_A_KEY_IN       7
`define RTF_A_SUBC_OUT     6
`define RTF_A_DIRECT       5
`define RTF_A_STAGE_SEL    4
`define RTF_A_CUT2         3
`define RTF_A_CUT1         2
`define RTF_A_FOLLOWER     1
`define RTF_A_GAIN_OBS     0

// Test control B fields
`define RTF_B_LEVEL_CHK    7
`define RTF_B_IO_HIGH      3
`define RTF_B_IO_LOW       2
`define RTF_B_RX_CHK       1
`define RTF_B_FAST_CLK     0
`define RTF_B_WR_MASK      8'h8f
`define RTF_B_STOP_MASK    8'hf1

// FIFO status and length
`define RTF_FIFO_DEPTH     12
`define RTF_FIFO_HIGH      9
`define RTF_FIFO_LOW       3
`define RTF_FULL_BYTE_BITS 4'h8

`endif

// file: verilog/rtf_fifo_level.v
// FIFO occupancy tracker with sticky overflow flag
// Assumes push and pop pulses come from the FIFO storage on mclk
`timescale 1ns/1ps
`include "rtf_defs.vh"
module rtf_fifo_level #(
    parameter DEPTH = `RTF_FIFO_DEPTH
) (
    input  wire       mclk,
    input  wire       reset_n,
    input  wire       clear,
    input  wire       push,
    input  wire       pop,
    input  wire       ovf_clear,
    output wire [4:0] count,
    output wire       overflow
);

reg  [4:0] count_ff;
reg        ovf_ff;
reg  [4:0] nxt_count;
reg        nxt_ovf;
wire       full;
wire       do_push;
wire       do_pop;

assign full    = (count_ff == DEPTH[4:0]);
// A pop frees room for a push in the same cycle
assign do_push = push & (~full | pop);
assign do_pop  = pop & (count_ff != 5'h00);

always @* begin
    nxt_count = count_ff;
    if (do_push & ~do_pop) begin
        nxt_count = count_ff + 5'h01;
    end else if (do_pop & ~do_push) begin
        nxt_count = count_ff - 5'h01;
    end
    // Overflow set wins over clear
    nxt_ovf = (ovf_ff & ~ovf_clear) | (push & full & ~pop);
    if (clear) begin
        nxt_count = 5'h00;
        nxt_ovf   = 1'b0;
    end
end

always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
        count_ff <= 5'h00;
        ovf_ff   <= 1'b0;
    end else begin
        count_ff <= nxt_count;
        ovf_ff   <= nxt_ovf;
    end
end

assign count    = count_ff;
assign overflow = ovf_ff;

endmodule

// file: verilog/rtf_sync2.v
// Two flip-flop synchroniser for pin levels
// Assumes inputs are asynchronous to mclk
`timescale 1ns/1ps
module rtf_sync2 #(
    parameter WIDTH = 1
) (
    input  wire             mclk,
    input  wire             reset_n,
    input  wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);

reg [WIDTH-1:0] meta_ff;
reg [WIDTH-1:0] sync_ff;

always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
        meta_ff <= {WIDTH{1'b0}};
        sync_ff <= {WIDTH{1'b0}};
    end else begin
        meta_ff <= async_in;
        sync_ff <= meta_ff;
    end
end

assign sync_out = sync_ff;

endmodule

// file: verilog/rtf_test_len_regs.v
// Test, FIFO status and transmit length register bank of the reader
// Assumes host interface logic on mclk gives register strobes and a stop
//
// Contract
// - Both test registers zero at reset
// - A bit7 routes keying pin to decoder
// - A bit6 drives receive subcarrier on shaping
// - A bit5 direct modulation plus receiver reset
// - A bit4 picks first or second stage
// - A bit3 cuts second stage gain
// - A bit2 cuts first stage gain
// - A bit0 shows gain level as strength
// - Receive or io check bit enters test
// - Host stop ends test, clears io and receive check bits
// - B bit0 runs coders at carrier rate
// - Status low nibble shows unread minus one
// - Status bit6 at nine bytes receiving
// - Status bit5 at three bytes transmitting
// - Status bit4 flags host write overflow
// - Status bit7 always reads zero
// - Twelve bit byte count across two registers
// - Length registers clear at reset, frame end
// - Partial bits used only with flag
// - Flag marks last byte narrower than eight
`timescale 1ns/1ps
`include "rtf_defs.vh"
module rtf_test_len_regs #(
    parameter FIFO_DEPTH = `RTF_FIFO_DEPTH,
    parameter FIFO_HIGH  = `RTF_FIFO_HIGH,
    parameter FIFO_LOW   = `RTF_FIFO_LOW
) (
    input  wire        mclk,
    input  wire        reset_n,
    input  wire        chip_enable,
    input  wire        reg_wr,
    input  wire        reg_rd,
    input  wire [4:0]  reg_addr,
    input  wire [7:0]  reg_wdata,
    output wire [7:0]  reg_rdata,
    input  wire        host_stop,
    input  wire        fifo_push,
    input  wire        fifo_pop,
    input  wire        rx_active,
    input  wire        tx_active,
    input  wire        tx_eof,
    input  wire        rx_subcarrier,
    input  wire        coder_modulation,
    input  wire        coder_keying,
    input  wire [2:0]  agc_level,
    input  wire [2:0]  rssi_level,
    input  wire        onoff_keying_pin_in,
    output wire        onoff_keying_pin_out,
    output wire        onoff_keying_pin_oe,
    input  wire        tx_shaping_pin_in,
    output wire        tx_shaping_pin_out,
    output wire        tx_shaping_pin_oe,
    output wire        decoder_input,
    output wire        tx_modulation,
    output wire        rx_reset,
    output wire        second_stage_select,
    output wire        second_stage_gain_cut,
    output wire        first_stage_gain_cut,
    output wire        input_follower_test,
    output wire [2:0]  signal_strength,
    output wire        test_mode,
    output wire        fast_coder_clock,
    output wire        carrier_level_check,
    output wire [11:0] tx_byte_count,
    output wire [2:0]  partial_byte_bits,
    output wire        partial_byte_flag,
    output wire [3:0]  tx_last_byte_bits
);

// Register value with a write applied, used by all writable registers
function [7:0] merge_wr;
    input [7:0] old_val;
    input [7:0] new_val;
    input       hit;
    begin
        merge_wr = hit ? new_val : old_val;
    end
endfunction

// Unread count shown as N - 1, empty shows zero
function [3:0] minus_one;
    input [4:0] n;
    begin
        if (n == 5'h00) begin
            minus_one = 4'h0;
        end else begin
            minus_one = n[3:0] - 4'h1;
        end
    end
endfunction

wire [1:0] pins_sync;
wire       enable_sync;
wire       key_pin_sync;
wire       shape_pin_sync;
wire [4:0] fifo_count;
wire       fifo_ovf;
wire       wr_a;
wire       wr_b;
wire       wr_hi;
wire       wr_lo;
wire       rd_stat;
wire       bank_clear;

reg  [7:0] test_a_ff;
reg  [7:0] test_b_ff;
reg  [7:0] txlen_hi_ff;
reg  [7:0] txlen_lo_ff;
reg  [7:0] rdata_ff;
reg        key_out_ff;
reg        key_oe_ff;
reg        shape_out_ff;
reg        shape_oe_ff;
reg        decoder_in_ff;
reg        tx_mod_ff;
reg        rx_reset_ff;
reg  [2:0] strength_ff;
reg        test_mode_ff;
reg  [3:0] last_bits_ff;
reg        fifo_high_ff;
reg        fifo_low_ff;

reg  [7:0] nxt_test_a;
reg  [7:0] nxt_test_b;
reg  [7:0] nxt_txlen_hi;
reg  [7:0] nxt_txlen_lo;
reg  [7:0] nxt_rdata;
reg  [3:0] nxt_last_bits;

// Pin levels pass two flip-flops before use
rtf_sync2 #(
    .WIDTH (2)
) u_pin_sync (
    .mclk     (mclk),
    .reset_n  (reset_n),
    .async_in ({onoff_keying_pin_in, tx_shaping_pin_in}),
    .sync_out (pins_sync)
);

rtf_sync2 #(
    .WIDTH (1)
) u_en_sync (
    .mclk     (mclk),
    .reset_n  (reset_n),
    .async_in (chip_enable),
    .sync_out (enable_sync)
);

assign key_pin_sync   = pins_sync[1];
assign shape_pin_sync = pins_sync[0];

// Enable low holds the bank in its reset state
assign bank_clear = ~enable_sync;

assign wr_a    = reg_wr & (reg_addr == `RTF_ADDR_TEST_A);
assign wr_b    = reg_wr & (reg_addr == `RTF_ADDR_TEST_B);
assign wr_hi   = reg_wr & (reg_addr == `RTF_ADDR_TXLEN_HI);
assign wr_lo   = reg_wr & (reg_addr == `RTF_ADDR_TXLEN_LO);
assign rd_stat = reg_rd & (reg_addr == `RTF_ADDR_FIFO_STAT);

rtf_fifo_level #(
    .DEPTH (FIFO_DEPTH)
) u_fifo_level (
    .mclk      (mclk),
    .reset_n   (reset_n),
    .clear     (bank_clear),
    .push      (fifo_push),
    .pop       (fifo_pop),
    .ovf_clear (rd_stat),
    .count     (fifo_count),
    .overflow  (fifo_ovf)
);

// Test control registers
always @* begin
    nxt_test_a = merge_wr(test_a_ff, reg_wdata, wr_a);
    nxt_test_b = merge_wr(test_b_ff, reg_wdata & `RTF_B_WR_MASK, wr_b);
    if (host_stop) begin
        // Io and receive check bits drop at the end of a host access
        nxt_test_b = nxt_test_b & `RTF_B_STOP_MASK;
    end
    if (bank_clear) begin
        nxt_test_a = `RTF_RESET_BYTE;
        nxt_test_b = `RTF_RESET_BYTE;
    end
end

// Transmit length registers
always @* begin
    nxt_txlen_hi = txlen_hi_ff;
    nxt_txlen_lo = txlen_lo_ff;
    if (tx_eof) begin
        nxt_txlen_hi = `RTF_RESET_BYTE;
        nxt_txlen_lo = `RTF_RESET_BYTE;
    end
    // Host write in the same cycle as frame end is kept
    nxt_txlen_hi = merge_wr(nxt_txlen_hi, reg_wdata, wr_hi);
    nxt_txlen_lo = merge_wr(nxt_txlen_lo, reg_wdata, wr_lo);
    if (bank_clear) begin
        nxt_txlen_hi = `RTF_RESET_BYTE;
        nxt_txlen_lo = `RTF_RESET_BYTE;
    end
end

// Width of the last transmitted byte
always @* begin
    nxt_last_bits = `RTF_FULL_BYTE_BITS;
    if (nxt_txlen_lo[0]) begin
        nxt_last_bits = {1'b0, nxt_txlen_lo[3:1]};
    end
end

// Read data, unmapped addresses read zero
always @* begin
    nxt_rdata = rdata_ff;
    if (reg_rd) begin
        case (reg_addr)
            `RTF_ADDR_TEST_A: begin
                nxt_rdata = test_a_ff;
            end
            `RTF_ADDR_TEST_B: begin
                nxt_rdata = test_b_ff;
            end
            `RTF_ADDR_FIFO_STAT: begin
                nxt_rdata = {1'b0,
                             fifo_high_ff,
                             fifo_low_ff,
                             fifo_ovf,
                             minus_one(fifo_count)};
            end
            `RTF_ADDR_TXLEN_HI: begin
                nxt_rdata = txlen_hi_ff;
            end
            `RTF_ADDR_TXLEN_LO: begin
                nxt_rdata = txlen_lo_ff;
            end
            default: begin
                nxt_rdata = 8'h00;
            end
        endcase
    end
end

always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
        test_a_ff    <= `RTF_RESET_BYTE;
        test_b_ff    <= `RTF_RESET_BYTE;
        txlen_hi_ff  <= `RTF_RESET_BYTE;
        txlen_lo_ff  <= `RTF_RESET_BYTE;
        rdata_ff     <= 8'h00;
        last_bits_ff <= `RTF_FULL_BYTE_BITS;
    end else begin
        test_a_ff    <= nxt_test_a;
        test_b_ff    <= nxt_test_b;
        txlen_hi_ff  <= nxt_txlen_hi;
        txlen_lo_ff  <= nxt_txlen_lo;
        rdata_ff     <= nxt_rdata;
        last_bits_ff <= nxt_last_bits;
    end
end

// FIFO watermarks
always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
        fifo_high_ff <= 1'b0;
        fifo_low_ff  <= 1'b0;
    end else begin
        fifo_high_ff <= rx_active &
                        (fifo_count >= FIFO_HIGH[4:0]);
        fifo_low_ff  <= tx_active &
                        (fifo_count <= FIFO_LOW[4:0]);
    end
end

// Pin routing and analogue control
always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
        key_out_ff    <= 1'b0;
        key_oe_ff     <= 1'b0;
        shape_out_ff  <= 1'b0;
        shape_oe_ff   <= 1'b0;
        decoder_in_ff <= 1'b0;
        tx_mod_ff     <= 1'b0;
        rx_reset_ff   <= 1'b0;
        strength_ff   <= 3'h0;
        test_mode_ff  <= 1'b0;
    end else begin
        // Keying pin turns input for the decoder
        key_oe_ff     <= ~test_a_ff[`RTF_A_KEY_IN];
        key_out_ff    <= coder_keying;
        decoder_in_ff <= test_a_ff[`RTF_A_KEY_IN] ?
                         key_pin_sync : rx_subcarrier;
        // Shaping pin: subcarrier out, direct input, or coder
        if (test_a_ff[`RTF_A_SUBC_OUT]) begin
            shape_oe_ff  <= 1'b1;
            shape_out_ff <= rx_subcarrier;
        end else if (test_a_ff[`RTF_A_DIRECT]) begin
            shape_oe_ff  <= 1'b0;
            shape_out_ff <= 1'b0;
        end else begin
            shape_oe_ff  <= 1'b1;
            shape_out_ff <= coder_modulation;
        end
        tx_mod_ff     <= test_a_ff[`RTF_A_DIRECT] ?
                         shape_pin_sync : coder_modulation;
        rx_reset_ff   <= test_a_ff[`RTF_A_DIRECT];
        strength_ff   <= test_a_ff[`RTF_A_GAIN_OBS] ?
                         agc_level : rssi_level;
        test_mode_ff  <= test_b_ff[`RTF_B_IO_HIGH] |
                         test_b_ff[`RTF_B_IO_LOW] |
                         test_b_ff[`RTF_B_RX_CHK];
    end
end

assign reg_rdata             = rdata_ff;
assign onoff_keying_pin_out  = key_out_ff;
assign onoff_keying_pin_oe   = key_oe_ff;
assign tx_shaping_pin_out    = shape_out_ff;
assign tx_shaping_pin_oe     = shape_oe_ff;
assign decoder_input         = decoder_in_ff;
assign tx_modulation         = tx_mod_ff;
assign rx_reset              = rx_reset_ff;
assign second_stage_select   = test_a_ff[`RTF_A_STAGE_SEL];
assign second_stage_gain_cut = test_a_ff[`RTF_A_CUT2];
assign first_stage_gain_cut  = test_a_ff[`RTF_A_CUT1];
assign input_follower_test   = test_a_ff[`RTF_A_FOLLOWER];
assign signal_strength       = strength_ff;
assign test_mode             = test_mode_ff;
assign fast_coder_clock      = test_b_ff[`RTF_B_FAST_CLK];
assign carrier_level_check   = test_b_ff[`RTF_B_LEVEL_CHK];
assign tx_byte_count         = {txlen_hi_ff, txlen_lo_ff[7:4]};
assign partial_byte_bits     = txlen_lo_ff[3:1];
assign partial_byte_flag     = txlen_lo_ff[0];
assign tx_last_byte_bits     = last_bits_ff;

endmodule
